// *** logic/dtmr_map.vh ***
`ifndef DTMR_MAP_VH
`define DTMR_MAP_VH

// register addresses
`define DTMR_CNT1_ADDR 16'hFF50
`define DTMR_CNT2_ADDR 16'hFF51
`define DTMR_CMP1_ADDR 16'hFF52
`define DTMR_CMP2_ADDR 16'hFF53
`define DTMR_MODE1_ADDR 16'hFF54
`define DTMR_MODE2_ADDR 16'hFF55
`define DTMR_PSC1_ADDR 16'hFF56
`define DTMR_PSC2_ADDR 16'hFF57

// reset values
`define DTMR_MODE_RESET 8'h00
`define DTMR_PSC_RESET 3'h0
`define DTMR_CMP_RESET 8'h00
`define DTMR_CNT_RESET 8'h00

// mode register fields
`define DTMR_COUNT_EN_BIT 7
`define DTMR_PWM_SEL_BIT 6
`define DTMR_CASCADE_BIT 4
`define DTMR_FORCE_SET_BIT 3
`define DTMR_FORCE_CLR_BIT 2
`define DTMR_INV_LVL_BIT 1
`define DTMR_OUT_EN_BIT 0

// bits kept in storage; force bits are never stored
`define DTMR_MODE1_KEEP 8'hC3
`define DTMR_MODE2_KEEP 8'hD3

// prescaler selection codes
`define DTMR_PSC_EXT_FALL 3'h0
`define DTMR_PSC_EXT_RISE 3'h1
`define DTMR_PSC_DIV4 3'h2
`define DTMR_PSC_DIV8 3'h3
`define DTMR_PSC_DIV16 3'h4
`define DTMR_PSC_DIV32 3'h5
`define DTMR_PSC_DIV128 3'h6
`define DTMR_PSC_DIV512 3'h7

// divider terminal masks, one less than each ratio
`define DTMR_MASK_DIV4 9'h003
`define DTMR_MASK_DIV8 9'h007
`define DTMR_MASK_DIV16 9'h00F
`define DTMR_MASK_DIV32 9'h01F
`define DTMR_MASK_DIV128 9'h07F
`define DTMR_MASK_DIV512 9'h1FF

`endif

// *** logic/dtmr_sync.v ***
`timescale 1ns/100ps
module dtmr_sync
#(
   parameter WIDTH = 2
)
(
   input wire clk,
   input wire resetn,
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] stage1;

   // first stage feeds only the second
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         stage1 <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end
      else
      begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end

endmodule // dtmr_sync

// *** logic/dtmr_prescale.v ***
`timescale 1ns/100ps
`include "dtmr_map.vh"
module dtmr_prescale
(
   input wire clk,
   input wire resetn,
   input wire run,
   input wire [2:0] sel,
   input wire ext_lvl,
   output reg tick
);

   reg [8:0] div;
   reg ext_prev;
   reg [8:0] mask;

   always @*
   begin
      case (sel)
         `DTMR_PSC_DIV4: mask = `DTMR_MASK_DIV4;
         `DTMR_PSC_DIV8: mask = `DTMR_MASK_DIV8;
         `DTMR_PSC_DIV16: mask = `DTMR_MASK_DIV16;
         `DTMR_PSC_DIV32: mask = `DTMR_MASK_DIV32;
         `DTMR_PSC_DIV128: mask = `DTMR_MASK_DIV128;
         `DTMR_PSC_DIV512: mask = `DTMR_MASK_DIV512;
         default: mask = `DTMR_MASK_DIV4;
      endcase
   end

   always @*
   begin
      case (sel)
         `DTMR_PSC_EXT_FALL: tick = run & ext_prev & ~ext_lvl; // R18
         `DTMR_PSC_EXT_RISE: tick = run & ~ext_prev & ext_lvl; // R18
         default: tick = run & ((div & mask) == mask); // R18
      endcase
   end

   // divider held at zero while stopped, so a restart gives a full first period
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         div <= 9'h000;
         ext_prev <= 1'b0;
      end
      else
      begin
         ext_prev <= ext_lvl;
         if (run)
         begin
            div <= div + 9'h001;
         end
         else
         begin
            div <= 9'h000; // R9
         end
      end
   end

endmodule // dtmr_prescale

// *** logic/dtmr_top.v ***
`timescale 1ns/100ps
// Operation
// R1: each channel has a read-only 8-bit counter stepping once per count pulse
// R2: a counter read defers a coinciding count pulse by one cycle
// R3: counter clears on reset, on count disable, and on match in clear mode
// R4: in cascade, disabling channel 1 clears the whole 16-bit count
// R5: match raises the channel interrupt pulse, except in pwm mode
// R6: compare registers take any byte and may be written while counting
// R7: software stops a cascaded timer before writing compare values
// R8: mode registers reset to zero and take bit or byte writes
// R9: bit 7 enables counting; clearing it zeroes counter and stops prescaler
// R10: bit 6 picks clear-on-match mode (0) or free-running pwm (1)
// R11: channel 2 bit 4 selects cascade; channel 1 bits 5 and 4 read zero
// R12: bits 3 and 2 force output flop clear or set; 11 is forbidden; here bit 3 sets and bit 2 clears
// R13: force bits act only when written and read back as zero
// R14: outside pwm, bit 1 enables output flop toggling on match
// R15: in pwm, bit 1 picks the active level, high when zero
// R16: bit 0 hands the pin to the timer output, else port logic
// R17: in pwm, count disable drives the output inactive
// R18: three-bit prescaler picks external edge or clock divided 4 to 512
// R19: with toggling on in clear mode, output flop toggles every match
// R20: in pwm, compare value sets the active width per 256-count period
// R21: cascade: channel 1 low byte, channel 2 high byte, 16-bit match
// R22: all register effects are synchronous to clk
`include "dtmr_map.vh"
module dtmr_top
(
   input wire clk,
   input wire resetn,
   input wire [15:0] bus_addr,
   input wire bus_wr,
   input wire bus_bit_wr,
   input wire [2:0] bus_bit_sel,
   input wire [7:0] bus_wdata,
   input wire bus_rd,
   output reg [7:0] bus_rdata,
   input wire chan1_ext_count_in,
   input wire chan2_ext_count_in,
   input wire chan1_port_out,
   input wire chan2_port_out,
   output wire chan1_out_pin,
   output wire chan2_out_pin,
   output wire chan1_match_irq,
   output wire chan2_match_irq
);

   // per-channel views, channel 1 in the low slice
   wire [15:0] mode_bus;
   wire [15:0] cnt_bus;
   wire [15:0] cmp_bus;
   wire [5:0] psc_bus;
   wire [1:0] step_bus;
   wire [1:0] run_bus;
   wire [1:0] pwm_bus;
   wire [1:0] pin_bus;
   wire [1:0] irq_bus;
   wire [1:0] ext_sync;
   wire [1:0] port_bus;

   wire cascade_sel;
   wire cnt_read;
   wire low_carry;
   wire match16;
   wire clear16;

   // byte write, or one bit replaced
   function [7:0] dtmr_merge;
      input [7:0] old;
      input byte_wr;
      input [2:0] bit_sel;
      input bit_val;
      begin
         dtmr_merge = old;
         if (byte_wr)
         begin
            dtmr_merge = bus_wdata;
         end
         else
         begin
            dtmr_merge[bit_sel] = bit_val;
         end
      end
   endfunction

   dtmr_sync
   #(
      .WIDTH(2)
   )
   u_ext_sync
   (
      .clk(clk),
      .resetn(resetn),
      .async_in({chan2_ext_count_in, chan1_ext_count_in}),
      .sync_out(ext_sync)
   );

   assign port_bus = {chan2_port_out, chan1_port_out};
   assign cascade_sel = mode_bus[8 + `DTMR_CASCADE_BIT]; // R11

   // a read of either counter holds both, so a cascaded pair reads coherently
   assign cnt_read = bus_rd & ((bus_addr == `DTMR_CNT1_ADDR) |
                               (bus_addr == `DTMR_CNT2_ADDR)); // R2

   // low byte rolling over carries into the high byte
   assign low_carry = step_bus[0] & (cnt_bus[7:0] == 8'hFF); // R21
   assign match16 = (cnt_bus == cmp_bus); // R21
   assign clear16 = cascade_sel & step_bus[0] & match16 & ~pwm_bus[0]; // R21

   genvar i;
   generate
      for (i = 0; i < 2; i = i + 1)
      begin : chan
         localparam [15:0] MODE_ADDR = (i == 0) ? `DTMR_MODE1_ADDR : `DTMR_MODE2_ADDR;
         localparam [15:0] CMP_ADDR = (i == 0) ? `DTMR_CMP1_ADDR : `DTMR_CMP2_ADDR;
         localparam [15:0] PSC_ADDR = (i == 0) ? `DTMR_PSC1_ADDR : `DTMR_PSC2_ADDR;
         localparam [7:0] KEEP = (i == 0) ? `DTMR_MODE1_KEEP : `DTMR_MODE2_KEEP;

         reg [7:0] mode;
         reg [7:0] cmp;
         reg [2:0] psc;
         reg [7:0] cnt;
         reg [7:0] next_cnt;
         reg out_ff;
         reg pwm_lvl;
         reg pin;
         reg irq;
         reg pend;

         wire wr_any;
         wire wr_mode;
         wire wr_cmp;
         wire wr_psc;
         wire [7:0] mode_new;
         wire [7:0] cmp_new;
         wire [7:0] psc_new;
         wire force_set;
         wire force_clr;
         wire en;
         wire pwm;
         wire inv;
         wire oe;
         wire run;
         wire raw_tick;
         wire step;
         wire own_match;
         wire event_hit;
         wire timer_out;

         assign wr_any = bus_wr | bus_bit_wr;
         assign wr_mode = wr_any & (bus_addr == MODE_ADDR);
         assign wr_cmp = wr_any & (bus_addr == CMP_ADDR);
         assign wr_psc = wr_any & (bus_addr == PSC_ADDR);

         assign mode_new = dtmr_merge(mode, bus_wr, bus_bit_sel, bus_wdata[0]); // R8
         assign cmp_new = dtmr_merge(cmp, bus_wr, bus_bit_sel, bus_wdata[0]);
         assign psc_new = dtmr_merge({5'h00, psc}, bus_wr, bus_bit_sel, bus_wdata[0]);

         // forbidden pattern 11 is ignored rather than guessed at
         assign force_set = wr_mode & mode_new[`DTMR_FORCE_SET_BIT] &
                            ~mode_new[`DTMR_FORCE_CLR_BIT]; // R12
         assign force_clr = wr_mode & mode_new[`DTMR_FORCE_CLR_BIT] &
                            ~mode_new[`DTMR_FORCE_SET_BIT]; // R12

         assign en = mode[`DTMR_COUNT_EN_BIT];
         assign pwm = mode[`DTMR_PWM_SEL_BIT]; // R10
         assign inv = mode[`DTMR_INV_LVL_BIT];
         assign oe = mode[`DTMR_OUT_EN_BIT];

         if (i == 0)
         begin : lo
            assign run = en; // R9
         end
         else
         begin : hi
            // cascaded high byte also stops with channel 1
            assign run = cascade_sel ? (en & run_bus[0]) : en; // R4
         end

         dtmr_prescale u_psc
         (
            .clk(clk),
            .resetn(resetn),
            .run(run),
            .sel(psc),
            .ext_lvl(ext_sync[i]),
            .tick(raw_tick)
         );

         // deferred pulse replays next cycle; pulses are never closer than two cycles
         assign step = pend | (raw_tick & ~cnt_read); // R2

         assign own_match = (cnt == cmp);

         if (i == 0)
         begin : lo_ev
            assign event_hit = ~cascade_sel & step & own_match & ~pwm; // R5
         end
         else
         begin : hi_ev
            assign event_hit = cascade_sel ? clear16 : (step & own_match & ~pwm); // R5
         end

         always @*
         begin
            next_cnt = cnt;
            if (!run)
            begin
               next_cnt = `DTMR_CNT_RESET; // R3
            end
            else if ((i == 0) && cascade_sel)
            begin
               if (clear16)
               begin
                  next_cnt = `DTMR_CNT_RESET; // R21
               end
               else if (step)
               begin
                  next_cnt = cnt + 8'h01; // R1
               end
            end
            else if ((i == 1) && cascade_sel)
            begin
               if (clear16)
               begin
                  next_cnt = `DTMR_CNT_RESET; // R21
               end
               else if (low_carry)
               begin
                  next_cnt = cnt + 8'h01; // R21
               end
            end
            else if (step)
            begin
               if (own_match && !pwm)
               begin
                  next_cnt = `DTMR_CNT_RESET; // R3
               end
               else
               begin
                  next_cnt = cnt + 8'h01; // R1
               end
            end
         end

         always @(posedge clk or negedge resetn)
         begin
            if (!resetn)
            begin
               mode <= `DTMR_MODE_RESET; // R8
               cmp <= `DTMR_CMP_RESET;
               psc <= `DTMR_PSC_RESET;
               cnt <= `DTMR_CNT_RESET; // R3
               pend <= 1'b0;
               irq <= 1'b0;
               out_ff <= 1'b0;
               pwm_lvl <= 1'b0;
               pin <= 1'b0;
            end
            else
            begin
               if (wr_mode)
               begin
                  mode <= mode_new & KEEP; // R11 R13
               end
               if (wr_cmp)
               begin
                  cmp <= cmp_new; // R6 R22
               end
               if (wr_psc)
               begin
                  psc <= psc_new[2:0]; // R18
               end
               pend <= run & raw_tick & cnt_read; // R2
               cnt <= next_cnt; // R22
               irq <= event_hit; // R5
               // forcing wins over a toggle in the same cycle
               if (force_set)
               begin
                  out_ff <= 1'b1; // R12
               end
               else if (force_clr)
               begin
                  out_ff <= 1'b0; // R12
               end
               else if (event_hit && inv && !pwm)
               begin
                  out_ff <= ~out_ff; // R14 R19
               end
               // active while count is below compare; idle when stopped
               pwm_lvl <= (run && (cnt < cmp)) ^ inv; // R15 R17 R20
               pin <= oe ? timer_out : port_bus[i]; // R16
            end
         end

         assign timer_out = pwm ? pwm_lvl : out_ff;

         assign mode_bus[8*i+7:8*i] = mode;
         assign cnt_bus[8*i+7:8*i] = cnt;
         assign cmp_bus[8*i+7:8*i] = cmp;
         assign psc_bus[3*i+2:3*i] = psc;
         assign step_bus[i] = step;
         assign run_bus[i] = run;
         assign pwm_bus[i] = pwm;
         assign pin_bus[i] = pin;
         assign irq_bus[i] = irq;
      end
   endgenerate

   // read data lands one cycle after the strobe; unmapped addresses read zero
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         bus_rdata <= 8'h00;
      end
      else if (bus_rd)
      begin
         case (bus_addr)
            `DTMR_CNT1_ADDR: bus_rdata <= cnt_bus[7:0]; // R1
            `DTMR_CNT2_ADDR: bus_rdata <= cnt_bus[15:8]; // R1
            `DTMR_CMP1_ADDR: bus_rdata <= cmp_bus[7:0];
            `DTMR_CMP2_ADDR: bus_rdata <= cmp_bus[15:8];
            `DTMR_MODE1_ADDR: bus_rdata <= mode_bus[7:0]; // R13
            `DTMR_MODE2_ADDR: bus_rdata <= mode_bus[15:8]; // R13
            `DTMR_PSC1_ADDR: bus_rdata <= {5'h00, psc_bus[2:0]};
            `DTMR_PSC2_ADDR: bus_rdata <= {5'h00, psc_bus[5:3]};
            default: bus_rdata <= 8'h00;
         endcase
      end
   end

   assign chan1_out_pin = pin_bus[0];
   assign chan2_out_pin = pin_bus[1];
   assign chan1_match_irq = irq_bus[0];
   assign chan2_match_irq = irq_bus[1];

endmodule // dtmr_top

// *** test/dtmr_assertions.sv ***
`timescale 1ns/100ps
module dtmr_checker
(
   input wire clk,
   input wire resetn,
   input wire [15:0] bus_addr,
   input wire bus_wr,
   input wire bus_bit_wr,
   input wire bus_rd,
   input wire [7:0] bus_wdata,
   input wire [7:0] bus_rdata,
   input wire chan1_out_pin,
   input wire chan1_match_irq,
   input wire chan2_match_irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   irq1_pulse_a: assert property (chan1_match_irq |=> !chan1_match_irq)
      else $error("channel 1 irq longer than one cycle");
   irq2_pulse_a: assert property (chan2_match_irq |=> !chan2_match_irq)
      else $error("channel 2 irq longer than one cycle");
   rdata_hold_a: assert property (!bus_rd |=> $stable(bus_rdata))
      else $error("read data moved without a read");
   mode1_fixed_a: assert property (bus_rd && bus_addr == 16'hFF54 |=> bus_rdata[5:2] == 4'h0)
      else $error("mode 1 fixed bits not zero");
   mode2_fixed_a: assert property (bus_rd && bus_addr == 16'hFF55 |=>
      !bus_rdata[5] && bus_rdata[3:2] == 2'h0) else $error("mode 2 fixed bits not zero");
   mode1_store_a: assert property (bus_wr && bus_addr == 16'hFF54 ##1
      !bus_wr && !bus_bit_wr ##1 bus_rd && bus_addr == 16'hFF54 |=>
      bus_rdata == ($past(bus_wdata, 3) & 8'hC3)) else $error("mode 1 readback wrong");
   mode2_store_a: assert property (bus_wr && bus_addr == 16'hFF55 ##1
      !bus_wr && !bus_bit_wr ##1 bus_rd && bus_addr == 16'hFF55 |=>
      bus_rdata == ($past(bus_wdata, 3) & 8'hD3)) else $error("mode 2 readback wrong");
   cmp_store_a: assert property (bus_wr && bus_addr == 16'hFF52 ##1
      !bus_wr && !bus_bit_wr ##1 bus_rd && bus_addr == 16'hFF52 |=>
      bus_rdata == $past(bus_wdata, 3)) else $error("compare readback wrong");
   reset_quiet_a: assert property ($rose(resetn) |->
      !chan1_match_irq && !chan2_match_irq && bus_rdata == 8'h00) else $error("not quiet");
   cover property (chan1_match_irq);
   cover property (chan2_match_irq);
   cover property ($rose(chan1_out_pin));
endmodule // dtmr_checker
bind dtmr_top dtmr_checker dtmr_checker_inst (.clk(clk), .resetn(resetn), .bus_addr(bus_addr),
   .bus_wr(bus_wr), .bus_bit_wr(bus_bit_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
   .bus_rdata(bus_rdata),
   .chan1_out_pin(chan1_out_pin), .chan1_match_irq(chan1_match_irq),
   .chan2_match_irq(chan2_match_irq));

// *** test/dtmr_tb.sv ***
`timescale 1ns/100ps
module testbench;
   reg clk = 1'b0;
   reg resetn = 1'b0;
   reg [15:0] bus_addr = 16'h0000;
   reg bus_wr = 1'b0;
   reg bus_bit_wr = 1'b0;
   reg [2:0] bus_bit_sel = 3'h0;
   reg [7:0] bus_wdata = 8'h00;
   reg bus_rd = 1'b0;
   reg ext1 = 1'b0;
   reg ext2 = 1'b0;
   reg port1 = 1'b0;
   reg port2 = 1'b1;
   wire [7:0] bus_rdata;
   wire pin1, pin2, irq1, irq2;
   int failures = 0;
   int checks_done = 0;
   int irqc1 = 0;
   int irqc2 = 0;
   int hi1 = 0;
   int g, i, c;
   reg [31:0] seed = 32'hE558;
   reg [7:0] mdl [0:7];
   int dv [0:7] = '{0, 0, 4, 8, 16, 32, 128, 512};
   dtmr_top dtmr_top_inst (.clk(clk), .resetn(resetn), .bus_addr(bus_addr), .bus_wr(bus_wr),
      .bus_bit_wr(bus_bit_wr), .bus_bit_sel(bus_bit_sel), .bus_wdata(bus_wdata),
      .bus_rd(bus_rd), .bus_rdata(bus_rdata), .chan1_ext_count_in(ext1),
      .chan2_ext_count_in(ext2), .chan1_port_out(port1), .chan2_port_out(port2),
      .chan1_out_pin(pin1), .chan2_out_pin(pin2), .chan1_match_irq(irq1),
      .chan2_match_irq(irq2));
   initial
   begin
      forever #5 clk = ~clk;
   end
   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // bits the model keeps per address; counters read 0 while stopped
   function [7:0] kmask(input [2:0] a);
      kmask = a == 3'h4 ? 8'hC3 : a == 3'h5 ? 8'hD3 : a[2] ? 8'h07 : a[1] ? 8'hFF : 8'h00;
   endfunction
   task end_of_test;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task check(input [15:0] got, input [15:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
         failures++;
      end
   endtask
   task cyc;
      @(posedge clk);
      #1;
      irqc1 += irq1;
      irqc2 += irq2;
      hi1 += pin1;
   endtask
   task wt(input int n);
      repeat (n) cyc;
   endtask
   task wr(input [15:0] a, input [7:0] d);
      bus_addr = a;
      bus_wdata = d;
      bus_wr = 1'b1;
      cyc;
      bus_wr = 1'b0;
      if (a[15:3] == 13'h1FEA)
         mdl[a[2:0]] = d & kmask(a[2:0]);
      // strobe stays low over one edge so a next call never re-raises it at once
      cyc;
   endtask
   task bwr(input [15:0] a, input [2:0] s, input v);
      bus_addr = a;
      bus_bit_sel = s;
      bus_wdata = {7'h00, v};
      bus_bit_wr = 1'b1;
      cyc;
      bus_bit_wr = 1'b0;
      cyc;
      mdl[a[2:0]][s] = v;
      mdl[a[2:0]] = mdl[a[2:0]] & kmask(a[2:0]);
   endtask
   task rdc(input [15:0] a, input [7:0] e);
      bus_addr = a;
      bus_rd = 1'b1;
      cyc;
      bus_rd = 1'b0;
      check(bus_rdata, e);
      cyc;
   endtask
   // clocks between two match pulses; the first wait only finds a pulse
   task gap(input int ch, output int n);
      int k;
      for (k = 0; k < 2; k++)
      begin
         n = 0;
         do
         begin
            cyc;
            n++;
            if (n > 3000)
            begin
               failures++;
               end_of_test;
            end
         end
         while ((ch == 1 ? irq1 : irq2) !== 1'b1);
      end
   endtask
   initial
   begin
      for (i = 0; i < 8; i++)
         mdl[i] = 8'h00;
      repeat (8) @(posedge clk);
      #1 resetn = 1'b1;
      for (i = 0; i < 9; i++)
         rdc(16'hFF50 + i[15:0], i < 8 ? mdl[i[2:0]] : 8'h00);
      wr(16'hFF50, 8'h55);
      rdc(16'hFF50, 8'h00);
      for (i = 0; i < 6; i++)
      begin
         seed = lfsr(seed);
         wr({15'h7FA9, i[0]}, i < 2 ? {8{i[0]}} : seed[7:0]);
         rdc({15'h7FA9, i[0]}, mdl[{2'h1, i[0]}]);
         wr({15'h7FAA, i[0]}, seed[15:8] & 8'h67);
         rdc({15'h7FAA, i[0]}, mdl[{2'h2, i[0]}]);
      end
      wr(16'hFF54, 8'h00);
      wr(16'hFF55, 8'h00);
      bwr(16'hFF54, 3'h0, 1'b1);
      bwr(16'hFF54, 3'h3, 1'b1);
      rdc(16'hFF54, mdl[4]);
      wr(16'hFF54, 8'h00);
      for (i = 0; i < 4; i++)
      begin
         seed = lfsr(seed);
         port1 = seed[0];
         wt(2);
         check(pin1, seed[0]);
      end
      wr(16'hFF55, 8'h09);
      wt(2);
      check(pin2, 1'b1);
      wr(16'hFF55, 8'h05);
      wt(2);
      check(pin2, 1'b0);
      wr(16'hFF55, 8'h0D);
      wt(2);
      check(pin2, 1'b0);
      rdc(16'hFF55, mdl[5]);
      // timer stopped around each prescale change, as software must
      for (c = 2; c < 8; c++)
      begin
         wr(16'hFF56, c[7:0]);
         wr(16'hFF52, 8'h00);
         wr(16'hFF54, 8'h80);
         gap(1, g);
         check(g[15:0], dv[c]);
         wr(16'hFF54, 8'h00);
      end
      wr(16'hFF56, 8'h02);
      wr(16'hFF52, 8'h03);
      wr(16'hFF54, 8'h83);
      gap(1, g);
      check(g[15:0], 16'd16);
      wt(2);
      c = pin1;
      wt(16);
      check(pin1, !c[0]);
      wr(16'hFF54, 8'h00);
      rdc(16'hFF50, 8'h00);
      irqc1 = 0;
      wt(40);
      check(irqc1[15:0], 16'd0);
      wr(16'hFF52, 8'h40);
      wr(16'hFF54, 8'hC1);
      wt(20);
      hi1 = 0;
      irqc1 = 0;
      wt(1024);
      check(hi1[15:0], 16'd256);
      check(irqc1[15:0], 16'd0);
      wr(16'hFF54, 8'hC3);
      wt(20);
      hi1 = 0;
      wt(1024);
      check(hi1[15:0], 16'd768);
      wr(16'hFF54, 8'h43);
      wt(3);
      check(pin1, 1'b1);
      wr(16'hFF54, 8'h41);
      wt(3);
      check(pin1, 1'b0);
      wr(16'hFF54, 8'h00);
      wr(16'hFF52, 8'h00);
      wr(16'hFF53, 8'h02);
      wr(16'hFF55, 8'h90);
      wr(16'hFF54, 8'h80);
      gap(2, g);
      check(g[15:0], 16'd2052);
      wt(1100);
      rdc(16'hFF51, 8'h01);
      wr(16'hFF54, 8'h00);
      rdc(16'hFF51, 8'h00);
      wr(16'hFF55, 8'h00);
      wr(16'hFF53, 8'h00);
      for (c = 0; c < 2; c++)
      begin
         wr(16'hFF57, c[7:0]);
         wr(16'hFF55, 8'h80);
         irqc2 = 0;
         repeat (3)
         begin
            ext2 = 1'b1;
            wt(6);
            ext2 = 1'b0;
            wt(6);
         end
         check(irqc2[15:0], 16'd3);
         wr(16'hFF55, 8'h00);
      end
      end_of_test;
   end
endmodule // testbench
